// ==== common/mdft_pkg.sv ====
/*
  Constants, register map and carrier types for the motor drive fault
  trip manager. Assumes a single 100 MHz system clock.
*/
// Behaviour
// RULE1: Latched trip clears on reset after condition.
// RULE2: Level trip self-clears, never enters history.
// RULE3: Any enabled fault halts the drive.
// RULE4: Simultaneous trips report the highest priority.
// RULE5: Motor overload trip gated by overload_enable.
// RULE6: Motor underload trip gated by underload_enable.
// RULE7: Overcurrent trip latches, no enable.
// RULE8: Overvoltage trip latches, no enable.
// RULE9: Undervoltage is level type, auto release.
// RULE10: Running undervoltage latches when enable is one.
// RULE11: Ground fault trip latches on output fault.
// RULE12: Ground fault only on supporting capacity variants.
// RULE13: Motor thermal trip gated by motor_thermal_enable.
// RULE14: Output phase loss needs config bit 1.
// RULE15: Input phase loss needs config bit 2.
// RULE16: Drive overload follows duty dependent time limits.
// RULE17: Missing motor while running, enable one.
// RULE18: Relay open at power-up, enabled variants only.
// RULE19: First over-torque when mode 3 or 4.
// RULE20: Second over-torque when mode 3 or 4.
// RULE21: First under-torque when mode 7 or 8.
// RULE22: Second under-torque when mode 7 or 8.
// RULE23: Active trip reported as distinct code.
package mdft_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CUR_W  = 16;
  localparam int LOAD_W = 9;

  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_TORQUE = 4'h1;
  localparam logic [ADDR_W-1:0] REG_LEVEL1 = 4'h2;
  localparam logic [ADDR_W-1:0] REG_LEVEL2 = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CODE   = 4'h5;

  localparam int CTRL_RESET_BIT = 8;
  localparam int PLC_LSB        = 12;
  localparam int T2_MODE_LSB    = 4;

  localparam logic [6:0]       CTRL_RST_VAL  = 7'h00;
  localparam logic [2:0]       PLC_RST_VAL   = 3'h0;
  localparam logic [3:0]       MODE_RST_VAL  = 4'h0;
  localparam logic [CUR_W-1:0] LEVEL_RST_VAL = 16'h0000;

  localparam logic [3:0] MODE_OVER_A  = 4'h3;
  localparam logic [3:0] MODE_OVER_B  = 4'h4;
  localparam logic [3:0] MODE_UNDER_A = 4'h7;
  localparam logic [3:0] MODE_UNDER_B = 4'h8;

  localparam int PLC_OUT_BIT = 1;
  localparam int PLC_IN_BIT  = 2;

  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  localparam logic [LOAD_W-1:0] ND_LONG_PCT  = 9'h096;
  localparam logic [LOAD_W-1:0] LD_LONG_PCT  = 9'h078;
  localparam logic [LOAD_W-1:0] SHORT_PCT    = 9'h0C8;
  localparam logic [15:0]       LONG_MS      = 16'hEA60;
  localparam logic [15:0]       ND_SHORT_MS  = 16'h0FA0;
  localparam logic [15:0]       LD_SHORT_MS  = 16'h07D0;

  localparam int NTRIP = 17;
  localparam int T_OCT = 0;
  localparam int T_OVT = 1;
  localparam int T_GFT = 2;
  localparam int T_LVT = 3;
  localparam int T_RUV = 4;
  localparam int T_IPO = 5;
  localparam int T_POT = 6;
  localparam int T_IOL = 7;
  localparam int T_ETH = 8;
  localparam int T_OLT = 9;
  localparam int T_ULT = 10;
  localparam int T_NMT = 11;
  localparam int T_ROT = 12;
  localparam int T_OT1 = 13;
  localparam int T_OT2 = 14;
  localparam int T_UT1 = 15;
  localparam int T_UT2 = 16;

  // Order follows bit index plus one, which is also the priority order.
  typedef enum logic [4:0] {
    TRIP_NONE, TRIP_OVER_CURRENT, TRIP_OVER_VOLTAGE, TRIP_GROUND,
    TRIP_LOW_VOLTAGE, TRIP_RUN_UNDERVOLTAGE, TRIP_IN_PHASE, TRIP_OUT_PHASE,
    TRIP_DRIVE_OVERLOAD, TRIP_MOTOR_THERMAL, TRIP_OVERLOAD, TRIP_UNDERLOAD,
    TRIP_NO_MOTOR, TRIP_RELAY_OPEN, TRIP_OVER_TORQUE_1, TRIP_OVER_TORQUE_2,
    TRIP_UNDER_TORQUE_1, TRIP_UNDER_TORQUE_2
  } mdft_trip_t;

  typedef struct packed {
    logic over_current;
    logic over_voltage;
    logic under_voltage;
    logic ground_fault;
    logic motor_overload;
    logic motor_underload;
    logic motor_thermal;
    logic out_phase_open;
    logic in_phase_open;
    logic no_motor;
    logic relay_open;
  } mdft_cond_t;

  typedef struct packed {
    logic light_duty;
    logic relay_check_enable;
    logic no_motor_enable;
    logic motor_thermal_enable;
    logic run_undervoltage_enable;
    logic underload_enable;
    logic overload_enable;
  } mdft_ctrl_t;

endpackage

// ==== hw/mdft_trip_manager.sv ====
/*
  Fault trip manager: synchronises protection comparator pins, latches
  or follows each trip, halts the drive, reports the highest priority
  trip and emits one history record per cycle with new latches, for the highest priority one.
  Assumes run, current and load words come from logic on clk_sys_in,
  and that condition pins are asynchronous to it.
*/
`timescale 1ns/1ps
module mdft_trip_manager #(
  parameter int         TICK_CNT     = mdft_pkg::TICK_CYCLES,
  parameter logic       GFT_PRESENT  = 1'b1,
  parameter logic       RELAY_PRESENT = 1'b0
) (
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_in,
  input  wire logic                        ce_in,
  input  wire mdft_pkg::mdft_cond_t        cond_pin_in,
  input  wire logic                        fault_reset_pin_in,
  input  wire logic                        run_in,
  input  wire logic [mdft_pkg::CUR_W-1:0]  current_in,
  input  wire logic [mdft_pkg::LOAD_W-1:0] load_pct_in,
  input  wire logic [mdft_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [mdft_pkg::DATA_W-1:0] wr_data_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic [mdft_pkg::DATA_W-1:0]      rd_data_out,
  output logic                             drive_halt_out,
  output mdft_pkg::mdft_trip_t             trip_code_out,
  output logic                             history_write_out,
  output mdft_pkg::mdft_trip_t             history_code_out
);
  import mdft_pkg::*;

  localparam int CW = $bits(mdft_cond_t);

  function automatic logic mode_is(input logic [3:0] m, input logic [3:0] a,
                                   input logic [3:0] b);
    mode_is = (m == a) || (m == b);
  endfunction

  // Lowest set index wins, so the vector order is the priority order.
  function automatic mdft_trip_t top_code(input logic [NTRIP-1:0] v);
    top_code = TRIP_NONE;
    for (int i = NTRIP - 1; i >= 0; i--) begin
      if (v[i]) begin
        top_code = mdft_trip_t'(5'(i + 1));
      end
    end
  endfunction

  // Pin synchroniser: stage 1 feeds stage 2 only; a change is taken once
  // stages 2 and 3 agree, which also rejects single-cycle glitches.
  logic [CW-1:0] s1_reg, s2_reg, s3_reg;
  logic [2:0]    rs_reg;
  mdft_cond_t    cond_reg;
  logic          frst_reg;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      rs_reg   <= 3'h0;
      cond_reg <= '0;
      frst_reg <= 1'b0;
    end else if (ce_in) begin
      s1_reg   <= cond_pin_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      rs_reg   <= {rs_reg[1:0], fault_reset_pin_in};
      cond_reg <= (s2_reg & s3_reg) | (cond_reg & (s2_reg | s3_reg));
      if (rs_reg[1] == rs_reg[2]) begin
        frst_reg <= rs_reg[2];
      end
    end
  end

  // Settings registers.
  mdft_ctrl_t       ctrl_reg;
  logic [2:0]       plc_reg;
  logic [3:0]       t1_mode_reg, t2_mode_reg;
  logic [CUR_W-1:0] t1_level_reg, t2_level_reg;
  logic             sw_reset_reg;
  logic             wr_hit;

  assign wr_hit = ce_in && wr_in;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl_reg     <= CTRL_RST_VAL;
      plc_reg      <= PLC_RST_VAL;
      t1_mode_reg  <= MODE_RST_VAL;
      t2_mode_reg  <= MODE_RST_VAL;
      t1_level_reg <= LEVEL_RST_VAL;
      t2_level_reg <= LEVEL_RST_VAL;
      sw_reset_reg <= 1'b0;
    end else if (ce_in) begin
      sw_reset_reg <= wr_hit && addr_in == REG_CTRL && wr_data_in[CTRL_RESET_BIT];
      if (wr_hit) begin
        case (addr_in)
          REG_CTRL: begin
            ctrl_reg <= wr_data_in[6:0];
            plc_reg  <= wr_data_in[PLC_LSB +: 3];
          end
          REG_TORQUE: begin
            t1_mode_reg <= wr_data_in[3:0];
            t2_mode_reg <= wr_data_in[T2_MODE_LSB +: 4];
          end
          REG_LEVEL1: t1_level_reg <= wr_data_in[CUR_W-1:0];
          REG_LEVEL2: t2_level_reg <= wr_data_in[CUR_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // Millisecond tick for the drive overload timers.
  logic [31:0] div_reg;
  logic        tick;

  assign tick = div_reg == 32'(TICK_CNT - 1);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      div_reg <= 32'h0;
    end else if (ce_in) begin
      div_reg <= tick ? 32'h0 : div_reg + 32'h1;
    end
  end

  // Drive overload: two bands, each with its own time budget. Falling
  // below a band restarts it; a coarse but safe inverse-time shape.
  logic [15:0]       long_ms_reg, short_ms_reg;
  logic [LOAD_W-1:0] long_pct;
  logic [15:0]       short_lim;
  logic              iol_cond;

  assign long_pct  = ctrl_reg.light_duty ? LD_LONG_PCT : ND_LONG_PCT;
  assign short_lim = ctrl_reg.light_duty ? LD_SHORT_MS : ND_SHORT_MS;
  assign iol_cond  = long_ms_reg >= LONG_MS || short_ms_reg >= short_lim;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      long_ms_reg  <= 16'h0;
      short_ms_reg <= 16'h0;
    end else if (ce_in) begin
      if (load_pct_in < long_pct) begin
        long_ms_reg <= 16'h0;
      end else if (tick && long_ms_reg < LONG_MS) begin
        long_ms_reg <= long_ms_reg + 16'h1; // RULE16
      end
      if (load_pct_in < SHORT_PCT) begin
        short_ms_reg <= 16'h0;
      end else if (tick && short_ms_reg < short_lim) begin
        short_ms_reg <= short_ms_reg + 16'h1; // RULE16
      end
    end
  end

  // Gated trip conditions, one bit per protection.
  logic [NTRIP-1:0] cause;
  logic             t1_over, t2_over, t1_under, t2_under;

  assign t1_over  = current_in > t1_level_reg;
  assign t2_over  = current_in > t2_level_reg;
  assign t1_under = current_in < t1_level_reg;
  assign t2_under = current_in < t2_level_reg;

  always_comb begin
    cause        = '0;
    cause[T_OCT] = cond_reg.over_current; // RULE7
    cause[T_OVT] = cond_reg.over_voltage; // RULE8
    cause[T_GFT] = GFT_PRESENT && cond_reg.ground_fault; // RULE11 RULE12
    cause[T_LVT] = cond_reg.under_voltage; // RULE9
    cause[T_RUV] = ctrl_reg.run_undervoltage_enable && run_in
                   && cond_reg.under_voltage; // RULE10
    cause[T_IPO] = plc_reg[PLC_IN_BIT] && cond_reg.in_phase_open; // RULE15
    cause[T_POT] = plc_reg[PLC_OUT_BIT] && cond_reg.out_phase_open; // RULE14
    cause[T_IOL] = iol_cond; // RULE16
    cause[T_ETH] = ctrl_reg.motor_thermal_enable && cond_reg.motor_thermal; // RULE13
    cause[T_OLT] = ctrl_reg.overload_enable && cond_reg.motor_overload; // RULE5
    cause[T_ULT] = ctrl_reg.underload_enable && cond_reg.motor_underload; // RULE6
    cause[T_NMT] = ctrl_reg.no_motor_enable && run_in && cond_reg.no_motor; // RULE17
    cause[T_ROT] = RELAY_PRESENT && ctrl_reg.relay_check_enable
                   && cond_reg.relay_open; // RULE18
    cause[T_OT1] = mode_is(t1_mode_reg, MODE_OVER_A, MODE_OVER_B) && t1_over; // RULE19
    cause[T_OT2] = mode_is(t2_mode_reg, MODE_OVER_A, MODE_OVER_B) && t2_over; // RULE20
    cause[T_UT1] = mode_is(t1_mode_reg, MODE_UNDER_A, MODE_UNDER_B) && t1_under; // RULE21
    cause[T_UT2] = mode_is(t2_mode_reg, MODE_UNDER_A, MODE_UNDER_B) && t2_under; // RULE22
  end

  // Trip state. A cause present in the clearing cycle keeps its bit set.
  localparam logic [NTRIP-1:0] LEVEL_MASK = NTRIP'(1) << T_LVT;

  logic [NTRIP-1:0] trip_reg, trip_next, new_latch;
  logic             clear_req;

  assign clear_req = frst_reg || sw_reset_reg;

  always_comb begin
    trip_next = trip_reg | cause; // RULE1
    if (clear_req) begin
      trip_next = cause; // RULE1
    end
    trip_next = (trip_next & ~LEVEL_MASK) | (cause & LEVEL_MASK); // RULE2 RULE9
  end

  assign new_latch = trip_next & ~trip_reg & ~LEVEL_MASK;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      trip_reg <= '0;
    end else if (ce_in) begin
      trip_reg <= trip_next;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      drive_halt_out    <= 1'b0;
      trip_code_out     <= TRIP_NONE;
      history_write_out <= 1'b0;
      history_code_out  <= TRIP_NONE;
    end else if (ce_in) begin
      drive_halt_out    <= |trip_reg; // RULE3
      trip_code_out     <= top_code(trip_reg); // RULE4 RULE23
      history_write_out <= |new_latch; // RULE2
      if (|new_latch) begin
        history_code_out <= top_code(new_latch); // RULE4
      end
    end
  end

  // Register reads; data stand for exactly one cycle after the strobe.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
    end else if (ce_in) begin
      rd_data_out <= '0;
      if (rd_in) begin
        case (addr_in)
          REG_CTRL:   rd_data_out <= {17'h0, plc_reg, 5'h0, ctrl_reg};
          REG_TORQUE: rd_data_out <= {24'h0, t2_mode_reg, t1_mode_reg};
          REG_LEVEL1: rd_data_out <= {16'h0, t1_level_reg};
          REG_LEVEL2: rd_data_out <= {16'h0, t2_level_reg};
          REG_STATUS: rd_data_out <= {15'h0, trip_reg};
          REG_CODE:   rd_data_out <= {26'h0, drive_halt_out, trip_code_out};
          default:    rd_data_out <= '0;
        endcase
      end
    end
  end

  chk_oct_latch_set: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE7
    ce_in && cond_reg.over_current |=> trip_reg[T_OCT])
    else $error("Overcurrent did not latch.");

  chk_latch_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE1
    ce_in && trip_reg[T_OVT] && !clear_req |=> trip_reg[T_OVT])
    else $error("Latched trip dropped without reset.");

  chk_level_release: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE9
    ce_in && !cond_reg.under_voltage |=> !trip_reg[T_LVT])
    else $error("Level trip did not release.");

  chk_overload_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE5
    ce_in && !trip_reg[T_OLT] && !ctrl_reg.overload_enable |=> !trip_reg[T_OLT])
    else $error("Overload tripped while disabled.");

  chk_halt_follows: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE3
    ce_in && trip_reg[T_OCT] |=> drive_halt_out)
    else $error("Drive not halted on trip.");

  chk_code_priority: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE4
    ce_in && trip_reg[T_OCT] |=> trip_code_out == TRIP_OVER_CURRENT)
    else $error("Wrong trip reported first.");

  chk_history_level: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE2
    history_write_out |-> history_code_out != TRIP_LOW_VOLTAGE)
    else $error("Level trip entered history.");

  chk_gft_absent: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE12
    !GFT_PRESENT |-> !trip_reg[T_GFT])
    else $error("Ground trip on variant without it.");

  chk_torque_over: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE19
    ce_in && t1_over && t1_mode_reg == MODE_OVER_B |=> trip_reg[T_OT1])
    else $error("Over-torque did not trip.");

  chk_pin_delay: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RULE8
    ce_in && s2_reg[CW-2] && s3_reg[CW-2] |=> cond_reg.over_voltage)
    else $error("Overvoltage pin not taken.");

endmodule

// ==== testbench/mdft_sensor_model.sv ====
/*
  Behavioural power stage comparators: the condition pins follow the
  requests of the bench after a chosen lag. Assumes that requests change
  just after a rising clock edge.
*/
`timescale 1ns/1ps
module mdft_sensor_model
  import mdft_pkg::*;
(
  input  wire logic                 clk_sys_in,
  input  wire mdft_pkg::mdft_cond_t cond_req_in,
  input  wire logic [3:0]           lag_in,
  output mdft_pkg::mdft_cond_t      cond_pin_out
);
  mdft_cond_t hist_reg [8];

  // A slow comparator settles late, so the lag is only changed while the pins are quiet.
  always_ff @(posedge clk_sys_in) begin
    hist_reg[0] <= cond_req_in;
    for (int i = 1; i < 8; i++) begin
      hist_reg[i] <= hist_reg[i-1];
    end
  end

  assign cond_pin_out = (lag_in == 4'h0) ? cond_req_in : hist_reg[lag_in[2:0] - 3'h1];
endmodule

// ==== testbench/testbench.sv ====
/*
  Self-checking bench for the fault trip manager: registers, latching,
  priority, enables, torque checks and drive overload timing.
  Assumes the sensor model drives the condition pins.
*/
`timescale 1ns/1ps
module testbench;
  import mdft_pkg::*;
  localparam int TICKS = 4;
  logic              clk_sys_in = 1'b0;
  logic              rst_in     = 1'b1;
  logic              ce_in      = 1'b1;
  mdft_cond_t        cond_req   = '0;
  mdft_cond_t        cond_pin;
  logic [3:0]        lag        = 4'h0;
  logic              frst_pin   = 1'b0;
  logic              run        = 1'b0;
  logic [CUR_W-1:0]  current    = 16'h0;
  logic [LOAD_W-1:0] load       = 9'h0;
  logic [ADDR_W-1:0] addr       = 4'h0;
  logic [DATA_W-1:0] wr_data    = 32'h0;
  logic              wr         = 1'b0;
  logic              rd         = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic              halt;
  mdft_trip_t        trip_code;
  logic              hist_wr;
  mdft_trip_t        hist_code;
  mdft_trip_t        last_hist  = TRIP_NONE;
  int                hist_count = 0;
  int                num_errors = 0;
  int                n_checks   = 0;
  logic [31:0]       v;
  logic [15:0]       lvl;
  mdft_trip_t        e;
  int                lim;
  int                pin_bit [11] = '{10, 9, 7, 8, 6, 5, 4, 3, 2, 1, 0};
  logic [31:0]       en_mask [11] = '{32'h0, 32'h0, 32'h0, 32'h4, 32'h1, 32'h2, 32'h8,
                                      32'h2000, 32'h4000, 32'h10, 32'h20};
  mdft_trip_t        exp_tab [11] = '{TRIP_OVER_CURRENT, TRIP_OVER_VOLTAGE, TRIP_GROUND,
                                      TRIP_RUN_UNDERVOLTAGE, TRIP_OVERLOAD, TRIP_UNDERLOAD,
                                      TRIP_MOTOR_THERMAL, TRIP_OUT_PHASE, TRIP_IN_PHASE,
                                      TRIP_NO_MOTOR, TRIP_NONE};
  logic [3:0]        regs    [7]  = '{REG_CTRL, REG_TORQUE, REG_LEVEL1, REG_LEVEL2,
                                      REG_STATUS, REG_CODE, 4'hA};
  logic [31:0]       masks   [7]  = '{32'h707F, 32'hFF, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0, 32'h0};
  logic [3:0]        modes   [6]  = '{4'h3, 4'h4, 4'h7, 4'h8, 4'h5, 4'h9};

  always #5 clk_sys_in = ~clk_sys_in;

  mdft_sensor_model mdft_sensor_model_inst (.clk_sys_in(clk_sys_in), .cond_req_in(cond_req),
    .lag_in(lag), .cond_pin_out(cond_pin));

  mdft_trip_manager #(.TICK_CNT(TICKS), .GFT_PRESENT(1'b1), .RELAY_PRESENT(1'b0))
    mdft_trip_manager_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
    .cond_pin_in(cond_pin), .fault_reset_pin_in(frst_pin), .run_in(run),
    .current_in(current), .load_pct_in(load), .addr_in(addr), .wr_data_in(wr_data),
    .wr_in(wr), .rd_in(rd), .rd_data_out(rd_data), .drive_halt_out(halt),
    .trip_code_out(trip_code), .history_write_out(hist_wr), .history_code_out(hist_code));

  always @(posedge clk_sys_in) begin
    if (hist_wr === 1'b1) begin
      hist_count <= hist_count + 1;
      last_hist  <= hist_code;
    end
  end

  function automatic mdft_trip_t torque_exp(input int ch, input logic [3:0] m);
    if (m == 4'h3 || m == 4'h4) return ch ? TRIP_OVER_TORQUE_2 : TRIP_OVER_TORQUE_1;
    if (m == 4'h7 || m == 4'h8) return ch ? TRIP_UNDER_TORQUE_2 : TRIP_UNDER_TORQUE_1;
    return TRIP_NONE;
  endfunction

  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr    <= a;
    wr_data <= d;
    wr      <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(negedge clk_sys_in);
    d = rd_data;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_trip(input mdft_trip_t x);
    @(negedge clk_sys_in);
    chk_val({26'h0, halt, trip_code}, {26'h0, x != TRIP_NONE, x});
    @(posedge clk_sys_in);
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  task automatic clear_faults(input logic [31:0] c);
    bus_write(REG_CTRL, c | 32'h100);
    wait_cycles(4);
  endtask

  task automatic wait_code(input mdft_trip_t x, input int n);
    int k;
    for (k = 0; k < n && trip_code !== x; k++) @(posedge clk_sys_in);
    if (k == n) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, trip_code, x);
      report_and_stop();
    end
    chk_trip(x);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h4C6FBE04));
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    for (int r = 0; r < 7; r++) begin
      bus_read(regs[r], v);
      chk_val(v, 32'h0);
      bus_write(regs[r], $urandom);
      bus_read(regs[r], v);
      chk_val(v, wr_data & masks[r]);
      bus_write(regs[r], 32'h0);
    end
    ce_in <= 1'b0;
    bus_write(REG_LEVEL1, 32'h1234);
    ce_in <= 1'b1;
    run   <= 1'b1;
    bus_read(REG_LEVEL1, v);
    chk_val(v, 32'h0);
    for (int i = 0; i < 11; i++) begin
      for (int p = 0; p < 2; p++) begin
        if (p == 0 && en_mask[i] == 32'h0) continue;
        e = p ? exp_tab[i] : TRIP_NONE;
        bus_write(REG_CTRL, p ? 32'h703F : 32'h703F & ~en_mask[i]);
        lag <= 4'($urandom_range(7, 0));
        hist_count = 0;
        cond_req[pin_bit[i]] <= 1'b1;
        wait_cycles(16);
        chk_trip(pin_bit[i] == 8 ? TRIP_LOW_VOLTAGE : e);
        frst_pin <= 1'b1;
        wait_cycles(6);
        frst_pin <= 1'b0;
        wait_cycles(8);
        cond_req[pin_bit[i]] <= 1'b0;
        wait_cycles(16);
        chk_trip(e);
        chk_val(hist_count, e != TRIP_NONE);
        if (e != TRIP_NONE) chk_val({27'h0, last_hist}, {27'h0, e});
        clear_faults(32'h0);
        chk_trip(TRIP_NONE);
      end
    end
    hist_count = 0;
    cond_req <= 11'h640;
    wait_cycles(16);
    chk_trip(TRIP_OVER_CURRENT);
    chk_val({27'h0, last_hist}, {27'h0, TRIP_OVER_CURRENT});
    cond_req <= 11'h200;
    // The pins lag by up to seven cycles plus the synchroniser, so let them settle.
    wait_cycles(16);
    clear_faults(32'h703F);
    chk_trip(TRIP_OVER_VOLTAGE);
    cond_req <= 11'h000;
    wait_cycles(16);
    clear_faults(32'h0);
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 6; m++) begin
        lvl = 16'h0100 + 16'($urandom_range(16'hFE00, 0));
        current <= lvl;
        bus_write(ch ? REG_LEVEL2 : REG_LEVEL1, {16'h0, lvl});
        bus_write(REG_TORQUE, ch ? {24'h0, modes[m], 4'h0} : {28'h0, modes[m]});
        chk_trip(TRIP_NONE);
        current <= (m == 0) ? lvl + 16'h1 : (m == 2) ? lvl - 16'h1 :
                   (m == 1 || m == 4) ? lvl + 16'h00FF : lvl - 16'h00FF;
        wait_cycles(4);
        chk_trip(torque_exp(ch, modes[m]));
        current <= lvl;
        bus_write(REG_TORQUE, 32'h0);
        clear_faults(32'h0);
      end
    end
    for (int d = 0; d < 2; d++) begin
      lim = d ? 2000 : 4000;
      bus_write(REG_CTRL, d ? 32'h707F : 32'h703F);
      load <= 9'h0C8;
      wait_cycles((lim - lim / 50) * TICKS);
      chk_trip(TRIP_NONE);
      wait_code(TRIP_DRIVE_OVERLOAD, (lim / 25) * TICKS);
      load <= 9'h000;
      clear_faults(32'h0);
      chk_trip(TRIP_NONE);
    end
    report_and_stop();
  end
endmodule
